// File: test/lpdic_ctrl_model.sv
/*
 * lpdic_ctrl_model: behavioural memory controller driving the command bus.
 * assumes: link_clk_i runs free; caller sequences the tasks one at a time.
 */
`timescale 1ns/10ps
`default_nettype none
module lpdic_ctrl_model
    import lpdic_pkg::*;
(
    input  wire logic      link_clk_i,
    output var lpdic_cmd_s cmd_o,
    output var logic       clk_en_o,
    output var logic       clock_stop_o
);
    initial begin
        cmd_o = '{CMD_NOP, 2'h0, 14'h0000};
        clk_en_o = 1'b1;
        clock_stop_o = 1'b0;
    end
    // idle bus toggles bank and address so stale values never look valid
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge link_clk_i);
            cmd_o <= '{CMD_NOP, ~cmd_o.bank, ~cmd_o.addr};
        end
    endtask
    task automatic send(input logic [3:0] c, input logic [1:0] b, input logic [ADDR_W-1:0] a);
        @(posedge link_clk_i);
        cmd_o <= '{c, b, a};
        idle(1);
    endtask
    task automatic set_en(input logic v);
        @(posedge link_clk_i);
        clk_en_o <= v;
    endtask
    task automatic set_stop(input logic v);
        @(posedge link_clk_i);
        clock_stop_o <= v;
    endtask
    task automatic refresh_twice();
        repeat (REFRESH_NEEDED) begin
            send(CMD_REFRESH, 2'h0, 14'h0000);
            idle(REFRESH_WAIT);
        end
    endtask
    task automatic init(input int settle, input logic [ADDR_W-1:0] base_v, ext_v, input logic late);
        idle(settle);
        send(CMD_PRECHARGE, 2'h0, 14'h0400);
        idle(PRECHARGE_WAIT);
        if (!late) refresh_twice();
        send(CMD_MODE_LOAD, late ? BANK_BASE : BANK_EXT, late ? base_v : ext_v);
        idle(MODE_LOAD_WAIT);
        send(CMD_MODE_LOAD, late ? BANK_EXT : BANK_BASE, late ? ext_v : base_v);
        idle(MODE_LOAD_WAIT);
        if (late) refresh_twice();
    endtask
endmodule
`default_nettype wire

// File: test/tb_lpdic_top.sv
/*
 * tb_lpdic_top: init sequence, mode loads and burst column order checks.
 * assumes: lpdic_ctrl_model drives the command bus on the link clock.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_lpdic_top;
    import lpdic_pkg::*;
    localparam int SETTLE = 20;
    logic mclk_i = 1'b0, link_clk_i = 1'b0, arst_n_i = 1'b0;
    lpdic_cmd_s          cmd;
    lpdic_mode_s         mode, mv;
    logic                clk_en, stop_req, ready, seq_err, stopped, active, rsync;
    logic [ADDR_W-1:0]   ext_mode, ext_v;
    logic [COL_W-1:0]    col;
    logic [2:0]          lat;
    int errors = 0, check_count = 0, cycles = 0, seed = 11993, bl, st, n;
    int q[$];

    initial forever #12.5 mclk_i = ~mclk_i;
    initial begin
        #3;
        forever #7.5 link_clk_i = ~link_clk_i;
    end

    lpdic_top #(.SETTLE_CYCLES(SETTLE)) lpdic_top_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .link_clk_i(link_clk_i), .clk_en_i(clk_en), .clock_stop_req_i(stop_req), .cmd_i(cmd),
        .mode_o(mode), .ext_mode_o(ext_mode), .ready_o(ready), .seq_error_o(seq_err),
        .clock_stopped_o(stopped), .burst_col_o(col), .burst_active_o(active), .ready_sync_o(rsync));
    lpdic_ctrl_model ctl (.link_clk_i(link_clk_i), .cmd_o(cmd), .clk_en_o(clk_en), .clock_stop_o(stop_req));

    task automatic chk_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t word got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // contents are lost on reset, so no default survives
    task automatic do_reset();
        arst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk_flag(ready, 1'b0);
        chk_word({7'h00, mode}, 14'h0000);
        repeat (3) @(posedge mclk_i);
        arst_n_i <= 1'b1;
    endtask
    function automatic int beat(int s, int b, int il, int i);
        int base = s & ~(b - 1);
        int off = s & (b - 1);
        return il ? (base | (off ^ i)) : (base | ((off + i) % b));
    endfunction

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        do_reset();
        ext_v = 14'($random(seed));
        ctl.set_stop(1'b1);
        fork
            ctl.init(SETTLE, {7'h00, RL_CODE_3, 1'b0, BL_CODE_8}, ext_v, 1'b1);
            begin
                repeat (30) @(posedge link_clk_i);
                #1;
                chk_flag(ready, 1'b0);
                chk_flag(stopped, 1'b0);
            end
        join
        ctl.idle(3);
        #1;
        chk_flag(ready, 1'b1);
        chk_flag(seq_err, 1'b0);
        chk_flag(stopped, 1'b1);
        chk_word({7'h00, mode}, {7'h00, BL_CODE_8, 1'b0, RL_CODE_3});
        chk_word(ext_mode, ext_v);
        repeat (4) @(posedge mclk_i);
        #1;
        chk_flag(rsync, 1'b1);
        ctl.set_stop(1'b0);
        ctl.idle(3);
        for (int b = 1; b <= 3; b++) begin
            for (int il = 0; il < 2; il++) begin
                bl = 1 << b;
                lat = il ? RL_CODE_2 : RL_CODE_3;
                mv = {b[2:0], il[0], lat};
                ctl.send(CMD_MODE_LOAD, BANK_BASE, {7'h00, lat, il[0], b[2:0]});
                ctl.idle(MODE_LOAD_WAIT);
                ext_v = 14'($random(seed));
                ctl.send(CMD_MODE_LOAD, BANK_EXT, ext_v);
                ctl.idle(MODE_LOAD_WAIT);
                // stray bank code must leave both registers alone
                ctl.send(CMD_MODE_LOAD, 2'h1, 14'($random(seed)));
                ctl.idle(MODE_LOAD_WAIT);
                #1;
                chk_word({7'h00, mode}, {7'h00, mv});
                chk_word(ext_mode, ext_v);
                st = $random(seed) & 32'h3ff;
                for (int i = 0; i < bl; i++) q.push_back(beat(st, bl, il, i));
                ctl.send(il ? CMD_READ : CMD_WRITE, 2'h0, 14'(st));
                n = 0;
                while (active !== 1'b1 && n < 6) begin
                    @(posedge link_clk_i);
                    #1;
                    n++;
                end
                chk_flag(active, 1'b1);
                // first column already stands in the cycle active is seen high
                for (int i = 0; i < bl; i++) begin
                    chk_word(14'(col), 14'(q.pop_front()));
                    @(posedge link_clk_i);
                    #1;
                end
                chk_flag(active, 1'b0);
            end
        end
        do_reset();
        ctl.init(SETTLE, {7'h00, RL_CODE_2, 1'b1, BL_CODE_4}, ext_v, 1'b0);
        ctl.idle(3);
        #1;
        chk_flag(ready, 1'b1);
        chk_word({7'h00, mode}, {7'h00, BL_CODE_4, 1'b1, RL_CODE_2});
        chk_flag(seq_err, 1'b0);
        do_reset();
        // commands are not flagged as sequence errors while enable is low
        ctl.set_en(1'b0);
        ctl.send(CMD_READ, 2'h0, 14'h0000);
        ctl.idle(2);
        #1;
        chk_flag(seq_err, 1'b0);
        ctl.set_en(1'b1);
        ctl.send(CMD_READ, 2'h0, 14'h0000);
        ctl.idle(2);
        #1;
        chk_flag(seq_err, 1'b1);
        chk_flag(ready, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire

// File: verilog/lpdic_order.sv
/*
 * lpdic_order: burst beat column generator, sequential or interleaved,
 * wrapping inside the aligned block; column output is registered.
 * assumes: start, mode and beat all on the link clock.
 */
`timescale 1ns/10ps
`default_nettype none
module lpdic_order
    import lpdic_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [COL_W-1:0]  start_col_i,
    input  wire logic [3:0]        len_i,
    input  wire logic              interleave_i,
    input  wire logic [2:0]        beat_i,
    output logic      [COL_W-1:0]  col_o
);
    wire logic [2:0] mask     = 3'(len_i - 4'h1);
    wire logic [2:0] low      = start_col_i[2:0];
    wire logic [2:0] seq_off  = 3'(low + beat_i) & mask;
    wire logic [2:0] ilv_off  = (low ^ beat_i) & mask;
    wire logic [2:0] off      = interleave_i ? ilv_off : seq_off;
    // upper bits pick the block, lower bits give position within
    wire logic [COL_W-1:0] next_col = {start_col_i[COL_W-1:3], (low & ~mask) | off};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) col_o <= '0;
        else          col_o <= next_col;
    end

    AST_WRAP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (((col_o ^ $past(start_col_i)) & ~COL_W'($past(len_i) - 4'h1)) == '0))
        else $error("burst column left its block");
endmodule
`default_nettype wire

// File: verilog/lpdic_pkg.sv
/*
 * lpdic_pkg: constants, command encodings, mode field layout and carrier
 * structs for the init and mode configuration block.
 * assumes: one command bus in the link clock domain, 14-bit address.
 */
package lpdic_pkg;
    localparam int          ADDR_W          = 14;
    localparam int          COL_W           = 10;
    // command encodings: {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0]  CMD_NOP         = 4'h7;
    localparam logic [3:0]  CMD_PRECHARGE   = 4'h2;
    localparam logic [3:0]  CMD_REFRESH     = 4'h1;
    localparam logic [3:0]  CMD_MODE_LOAD   = 4'h0;
    localparam logic [3:0]  CMD_READ        = 4'h5;
    localparam logic [3:0]  CMD_WRITE       = 4'h4;
    localparam logic [3:0]  CMD_ACTIVE      = 4'h3;
    localparam logic [3:0]  CMD_BURST_STOP  = 4'h6;
    // mode register field positions
    localparam int          BL_LSB          = 0;
    localparam int          BT_BIT          = 3;
    localparam int          RL_LSB          = 4;
    localparam logic [2:0]  BL_CODE_2       = 3'h1;
    localparam logic [2:0]  BL_CODE_4       = 3'h2;
    localparam logic [2:0]  BL_CODE_8       = 3'h3;
    localparam logic [2:0]  RL_CODE_2       = 3'h2;
    localparam logic [2:0]  RL_CODE_3       = 3'h3;
    localparam logic [1:0]  BANK_BASE       = 2'h0;
    localparam logic [1:0]  BANK_EXT        = 2'h2;
    localparam logic [13:0] MODE_RESET      = 14'h0000;
    localparam int          REFRESH_NEEDED  = 2;
    // timing
    localparam real         LINK_MHZ        = 66.6;
    localparam real         SETTLE_US       = 200.0;
    localparam int          SETTLE_CYC      = int'($ceil(SETTLE_US * LINK_MHZ));
    localparam int          PRECHARGE_WAIT  = 3;
    localparam int          REFRESH_WAIT    = 6;
    localparam int          MODE_LOAD_WAIT  = 2;

    typedef struct packed {
        logic [3:0]         cmd;
        logic [1:0]         bank;
        logic [ADDR_W-1:0]  addr;
    } lpdic_cmd_s;

    typedef struct packed {
        logic [2:0]         burst_len;
        logic               interleave;
        logic [2:0]         read_lat;
    } lpdic_mode_s;
endpackage

// File: verilog/lpdic_top.sv
/*
 * lpdic_top: device-side power-up sequence tracker and mode register for
 * a low-power ddr memory; decodes the command bus, checks the init steps,
 * holds mode fields and steps burst column order.
 * assumes: command pins driven by an external controller on link_clk_i;
 * mclk_i side only reads the synchronised status.
 */
`timescale 1ns/10ps
`default_nettype none
module lpdic_top
    import lpdic_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
)(
    input  wire logic              mclk_i,
    input  wire logic              arst_n_i,
    input  wire logic              link_clk_i,
    input  wire logic              clk_en_i,
    input  wire logic              clock_stop_req_i,
    input  wire lpdic_cmd_s        cmd_i,
    output lpdic_mode_s            mode_o,
    output logic [ADDR_W-1:0]      ext_mode_o,
    output logic                   ready_o,
    output logic                   seq_error_o,
    output logic                   clock_stopped_o,
    output logic [COL_W-1:0]       burst_col_o,
    output logic                   burst_active_o,
    output logic                   ready_sync_o
);
    typedef enum {ST_SETTLE, ST_WAIT_PRE, ST_CONFIG, ST_READY} lpdic_state_e;

    lpdic_state_e state;
    lpdic_state_e next_state;
    logic [31:0]  settle_cnt;
    logic [3:0]   wait_cnt;
    logic [1:0]   refresh_cnt;
    logic         base_done;
    logic         ext_done;
    logic [13:0]  mode_reg;
    logic [COL_W-1:0] start_col;
    logic [2:0]   beat;
    logic [1:0]   ready_meta;

    wire logic is_nop     = cmd_i.cmd[3] || (cmd_i.cmd == CMD_NOP);
    wire logic waiting    = (wait_cnt != 4'h0);
    wire logic is_pre     = (cmd_i.cmd == CMD_PRECHARGE) && cmd_i.addr[10];
    wire logic is_ref     = (cmd_i.cmd == CMD_REFRESH);
    wire logic is_load    = (cmd_i.cmd == CMD_MODE_LOAD);
    wire logic load_base  = is_load && (cmd_i.bank == BANK_BASE);
    wire logic load_ext   = is_load && (cmd_i.bank == BANK_EXT);
    wire logic is_rw      = (cmd_i.cmd == CMD_READ) || (cmd_i.cmd == CMD_WRITE);
    wire logic cfg_done   = base_done && ext_done && (refresh_cnt == 2'(REFRESH_NEEDED)) && !waiting;
    wire logic settled    = (settle_cnt >= 32'(SETTLE_CYCLES));
    // in config, only the init commands are legal and only outside a wait;
    // the precharge that closes settling is the one legal command before it
    wire logic bad_cmd    = !is_nop && clk_en_i && (
                                (state == ST_SETTLE && !(settled && is_pre)) ||
                                (state == ST_WAIT_PRE) ||
                                (state == ST_CONFIG && (waiting || !(is_ref || load_base || load_ext))));
    wire logic [2:0] bl_code = mode_reg[BL_LSB +: 3];
    wire logic [3:0] bl_len  = (bl_code == BL_CODE_8) ? 4'h8 :
                               (bl_code == BL_CODE_4) ? 4'h4 : 4'h2;

    always_comb begin
        next_state = state;
        case (state)
            ST_SETTLE:   if (settle_cnt >= 32'(SETTLE_CYCLES) && is_pre) next_state = ST_WAIT_PRE;
            ST_WAIT_PRE: if (!waiting) next_state = ST_CONFIG;
            ST_CONFIG:   if (cfg_done) next_state = ST_READY;
            ST_READY:    next_state = ST_READY;
            default:     next_state = ST_SETTLE;
        endcase
    end

    always_ff @(posedge link_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) state <= ST_SETTLE;
        else if (clk_en_i) state <= next_state;
    end

    // settle count only runs on valid clocks with enable high
    always_ff @(posedge link_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) settle_cnt <= '0;
        else if (clk_en_i && state == ST_SETTLE && settle_cnt < 32'(SETTLE_CYCLES)) settle_cnt <= settle_cnt + 32'h0000_0001;
    end

    always_ff @(posedge link_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) wait_cnt <= '0;
        else if (state == ST_SETTLE && next_state == ST_WAIT_PRE) wait_cnt <= 4'(PRECHARGE_WAIT);
        else if (state == ST_CONFIG && !waiting && is_ref) wait_cnt <= 4'(REFRESH_WAIT);
        else if (state == ST_CONFIG && !waiting && is_load) wait_cnt <= 4'(MODE_LOAD_WAIT);
        else if (waiting) wait_cnt <= wait_cnt - 4'h1;
    end

    always_ff @(posedge link_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            refresh_cnt <= '0;
            base_done   <= 1'b0;
            ext_done    <= 1'b0;
        end else if (state == ST_CONFIG && !waiting) begin
            if (is_ref && refresh_cnt != 2'(REFRESH_NEEDED)) refresh_cnt <= refresh_cnt + 2'h1;
            if (load_base) base_done <= 1'b1;
            if (load_ext)  ext_done  <= 1'b1;
        end
    end

    // no reload path other than a base or extended load; power loss is the reset
    always_ff @(posedge link_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_reg   <= MODE_RESET;
            ext_mode_o <= MODE_RESET;
        end else begin
            if (load_base && (state == ST_CONFIG || state == ST_READY)) mode_reg <= cmd_i.addr;
            if (load_ext && (state == ST_CONFIG || state == ST_READY)) ext_mode_o <= cmd_i.addr;
        end
    end

    always_ff @(posedge link_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_o          <= '0;
            ready_o         <= 1'b0;
            seq_error_o     <= 1'b0;
            clock_stopped_o <= 1'b0;
        end else begin
            mode_o.burst_len  <= mode_reg[BL_LSB +: 3];
            mode_o.interleave <= mode_reg[BT_BIT];
            mode_o.read_lat   <= mode_reg[RL_LSB +: 3];
            ready_o           <= (next_state == ST_READY);
            seq_error_o       <= seq_error_o | bad_cmd;
            clock_stopped_o   <= clock_stop_req_i && (state == ST_READY);
        end
    end

    // one burst length serves reads and writes alike
    always_ff @(posedge link_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            start_col      <= '0;
            beat           <= '0;
            burst_active_o <= 1'b0;
        end else if (state == ST_READY && is_rw) begin
            start_col      <= cmd_i.addr[COL_W-1:0];
            beat           <= '0;
            burst_active_o <= 1'b1;
        end else if (burst_active_o) begin
            beat           <= beat + 3'h1;
            burst_active_o <= (4'(beat) + 4'h1) < bl_len;
        end
    end

    lpdic_order u_order (
        .clk_i        (link_clk_i),
        .rst_n_i      (arst_n_i),
        .start_col_i  (start_col),
        .len_i        (bl_len),
        .interleave_i (mode_reg[BT_BIT]),
        .beat_i       (beat),
        .col_o        (burst_col_o)
    );

    // ready level into the system clock domain
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ready_meta   <= '0;
            ready_sync_o <= 1'b0;
        end else begin
            ready_meta   <= {ready_meta[0], ready_o};
            ready_sync_o <= ready_meta[1];
        end
    end

    sequence s_ready_seen;
        ready_o;
    endsequence

    AST_STOP_BEFORE_READY: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
        clock_stopped_o |-> ready_o)
        else $error("clock stop honoured before ready");
    AST_READY_NEEDS_LOADS: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
        $rose(ready_o) |-> base_done && ext_done && refresh_cnt == 2'(REFRESH_NEEDED))
        else $error("ready without both loads and refreshes");
    AST_READY_STICKS: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
        s_ready_seen |=> ready_o)
        else $error("ready dropped");
    AST_BASE_LOAD: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
        load_base && state == ST_READY |=> mode_reg == $past(cmd_i.addr))
        else $error("base load not stored");
    AST_EXT_LOAD: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
        load_ext && state == ST_READY |=> ext_mode_o == $past(cmd_i.addr))
        else $error("extended load not stored");
    AST_MODE_HOLD: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
        !load_base |=> $stable(mode_reg))
        else $error("base register changed without load");
    AST_FIELDS: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
        ##2 mode_o.read_lat == $past(mode_reg[RL_LSB +: 3]))
        else $error("latency field misplaced");
    AST_BURST_LEN: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
        $rose(burst_active_o) && bl_code == BL_CODE_4 && !is_rw |-> burst_active_o[*4] ##1 !burst_active_o)
        else $error("burst of four wrong length");
endmodule
`default_nettype wire
